// >>> common/usb_ep_irq_regs.svh
// Register offsets, field positions and reset values of the endpoint interrupt mask block
`ifndef USB_EP_IRQ_REGS_SVH
`define USB_EP_IRQ_REGS_SVH
// ==========================================
// Register offsets (byte addresses)
`define EPI_IN_MASK_OFS 8'h00
`define EPI_OUT_MASK_OFS 8'h04
`define EPI_SUMMARY_OFS 8'h08
`define EPI_ALL_MASK_OFS 8'h0c
`define EPI_EV_STATUS_OFS 8'h10
`define EPI_EV_MASK_OFS 8'h14
// ==========================================
// Common IN mask fields
`define EPI_IN_BNA_BIT 9
`define EPI_IN_UNDERRUN_BIT 8
`define EPI_IN_NAK_EFF_BIT 6
`define EPI_IN_TKN_MISMATCH_BIT 5
`define EPI_IN_TKN_EMPTY_BIT 4
`define EPI_IN_TIMEOUT_BIT 3
`define EPI_EP_DISABLED_BIT 1
`define EPI_XFER_DONE_BIT 0
`define EPI_IN_WR_BITS 10'h37b
// ==========================================
// Common OUT mask fields
`define EPI_OUT_BNA_BIT 9
`define EPI_OUT_PKT_ERR_BIT 8
`define EPI_OUT_B2B_SETUP_BIT 6
`define EPI_OUT_TKN_DIS_BIT 4
`define EPI_OUT_SETUP_DONE_BIT 3
`define EPI_OUT_WR_BITS 10'h35b
// ==========================================
// Summary layout and reset values
`define EPI_OUT_SUM_LSB 16
`define EPI_IN_SUM_LSB 0
`define EPI_MASK_RESET 10'h000
`define EPI_ALL_MASK_RESET 8'h00
`define EPI_EV_RESET 2'h0
`endif

// >>> common/usb_ep_irq_pkg.sv
// Types shared by the endpoint interrupt mask block
`default_nettype none
package usb_ep_irq_pkg;
   // ==========================================
   // Register port request
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } bus_req_type;
   // ==========================================
   // Raw per-endpoint status of one direction
   typedef struct packed {
      logic [7:0][9:0] status;
      logic [7:0] kind;
   } ep_side_type;
endpackage
`default_nettype wire

// >>> rtl/usb_ep_irq_mask.sv
// Endpoint interrupt masking and aggregation for a full-speed USB device
`timescale 1ns/1ps
`default_nettype none
`include "usb_ep_irq_regs.svh"

// Summary of operation
// RULE1: Each IN endpoint status event is gated by its common IN mask bit.
// RULE2: Common IN mask resets to zero, all IN events masked.
// RULE3: IN mask bits 9,8,6,5,4,3,1,0 writable; others reserved, read zero.
// RULE4: IN timeout mask bit 3 applies only to non-isochronous endpoints.
// RULE5: OUT mask bits 9,8,6,4,3,1,0 writable; one means unmasked.
// RULE6: SETUP done mask applies only to control endpoints.
// RULE7: Common OUT mask resets to zero, all OUT events masked.
// RULE8: One summary bit per endpoint, eight IN and eight OUT.
// RULE9: OUT summary at bits 23:16, IN at 7:0, read-only.
// RULE10: Bidirectional endpoint uses its IN and OUT summary bits together.
// RULE11: Summary bits follow endpoint status, including software clears.
// RULE12: All-endpoints mask mirrors summary layout, resets to zero.
// RULE13: All-endpoints masking never stops the summary bit being set.
// RULE14: Endpoint request high while any summary bit and its mask bit set.
module usb_ep_irq_mask (
   // Clock and reset
   input wire logic SYS_CLK,
   input wire logic RESET,
   // Register port
   input wire usb_ep_irq_pkg::bus_req_type BUS,
   output logic [31:0] RDATA,
   // Per-endpoint status from the core, kind is isochronous flag
   input wire usb_ep_irq_pkg::ep_side_type IN_EPS,
   // Per-endpoint status from the core, kind is control flag
   input wire usb_ep_irq_pkg::ep_side_type OUT_EPS,
   // Requests to the global interrupt logic
   output logic EP_IRQ,
   output logic IRQ
);

   // ==========================================
   // Storage
   logic [9:0] in_mask;
   logic [9:0] out_mask;
   logic [7:0] in_all_mask;
   logic [7:0] out_all_mask;
   logic [7:0] in_sum;
   logic [7:0] out_sum;
   logic [7:0] last_in_sum;
   logic [7:0] last_out_sum;
   logic [1:0] ev_status;
   logic [1:0] ev_mask;
   logic [7:0] next_in_sum;
   logic [7:0] next_out_sum;
   logic [1:0] next_ev_status;
   logic [1:0] ev_set;
   logic [1:0] ev_clr;
   logic [31:0] next_rdata;
   logic wr_in_mask;
   logic wr_out_mask;
   logic wr_all_mask;
   logic wr_ev_status;
   logic wr_ev_mask;

   assign wr_in_mask = BUS.wr && BUS.addr == `EPI_IN_MASK_OFS;
   assign wr_out_mask = BUS.wr && BUS.addr == `EPI_OUT_MASK_OFS;
   assign wr_all_mask = BUS.wr && BUS.addr == `EPI_ALL_MASK_OFS;
   assign wr_ev_status = BUS.wr && BUS.addr == `EPI_EV_STATUS_OFS;
   assign wr_ev_mask = BUS.wr && BUS.addr == `EPI_EV_MASK_OFS;

   // ==========================================
   // Common masks, reserved bits never stored
   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         in_mask <= `EPI_MASK_RESET; // RULE2
      end else if (wr_in_mask) begin
         in_mask <= BUS.wdata[9:0] & `EPI_IN_WR_BITS; // RULE3
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         out_mask <= `EPI_MASK_RESET; // RULE7
      end else if (wr_out_mask) begin
         out_mask <= BUS.wdata[9:0] & `EPI_OUT_WR_BITS; // RULE5
      end
   end

   // ==========================================
   // All-endpoints mask
   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         in_all_mask <= `EPI_ALL_MASK_RESET; // RULE12
         out_all_mask <= `EPI_ALL_MASK_RESET; // RULE12
      end else if (wr_all_mask) begin
         in_all_mask <= BUS.wdata[7:0]; // RULE12
         out_all_mask <= BUS.wdata[23:16]; // RULE12
      end
   end

   // ==========================================
   // Per-endpoint gating into summary bits
   genvar ep;
   generate
      for (ep = 0; ep < 8; ep = ep + 1) begin : gen_ep
         logic [9:0] in_gate;
         logic [9:0] out_gate;
         always_comb begin
            in_gate = in_mask; // RULE1
            // Isochronous endpoints never raise timeouts
            if (IN_EPS.kind[ep]) begin
               in_gate[`EPI_IN_TIMEOUT_BIT] = 1'b0; // RULE4
            end
            out_gate = out_mask;
            // SETUP done only counts on control endpoints
            if (!OUT_EPS.kind[ep]) begin
               out_gate[`EPI_OUT_SETUP_DONE_BIT] = 1'b0; // RULE6
            end
         end
         assign next_in_sum[ep] = |(IN_EPS.status[ep] & in_gate); // RULE1
         assign next_out_sum[ep] = |(OUT_EPS.status[ep] & out_gate); // RULE5
      end
   endgenerate

   // Summary tracks status both ways, no stickiness here
   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         in_sum <= 8'h00;
         out_sum <= 8'h00;
      end else begin
         in_sum <= next_in_sum; // RULE8 RULE10 RULE11
         out_sum <= next_out_sum; // RULE8 RULE10 RULE11
      end
   end

   // ==========================================
   // Endpoint request, summary kept regardless of mask
   // Registered so a mask write never glitches the request
   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         EP_IRQ <= 1'b0;
      end else begin
         EP_IRQ <= |({out_sum & out_all_mask, in_sum & in_all_mask}); // RULE13 RULE14
      end
   end

   // ==========================================
   // Sticky events: any summary bit rising per direction
   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         last_in_sum <= 8'h00;
         last_out_sum <= 8'h00;
      end else begin
         last_in_sum <= in_sum;
         last_out_sum <= out_sum;
      end
   end

   assign ev_set = {|(out_sum & ~last_out_sum), |(in_sum & ~last_in_sum)};
   assign ev_clr = wr_ev_status ? BUS.wdata[1:0] : 2'h0;
   // Set beats clear so a same-cycle event is kept
   assign next_ev_status = (ev_status & ~ev_clr) | ev_set;

   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         ev_status <= `EPI_EV_RESET;
      end else begin
         ev_status <= next_ev_status;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         ev_mask <= `EPI_EV_RESET;
      end else if (wr_ev_mask) begin
         ev_mask <= BUS.wdata[1:0];
      end
   end

   // A new event mask reaches the request one cycle after the write
   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         IRQ <= 1'b0;
      end else begin
         IRQ <= |(next_ev_status & ev_mask);
      end
   end

   // ==========================================
   // Read path, one cycle latency, unmapped reads zero
   always_comb begin
      next_rdata = 32'h0000_0000;
      case (BUS.addr)
         `EPI_IN_MASK_OFS: begin
            next_rdata[9:0] = in_mask;
         end
         `EPI_OUT_MASK_OFS: begin
            next_rdata[9:0] = out_mask;
         end
         `EPI_SUMMARY_OFS: begin
            next_rdata[`EPI_OUT_SUM_LSB +: 8] = out_sum; // RULE9
            next_rdata[`EPI_IN_SUM_LSB +: 8] = in_sum; // RULE9
         end
         `EPI_ALL_MASK_OFS: begin
            next_rdata[23:16] = out_all_mask;
            next_rdata[7:0] = in_all_mask;
         end
         `EPI_EV_STATUS_OFS: begin
            next_rdata[1:0] = ev_status;
         end
         `EPI_EV_MASK_OFS: begin
            next_rdata[1:0] = ev_mask;
         end
         default: begin
            next_rdata = 32'h0000_0000;
         end
      endcase
   end

   // Data only in the cycle after the strobe
   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         RDATA <= 32'h0000_0000;
      end else if (BUS.rd) begin
         RDATA <= next_rdata;
      end else begin
         RDATA <= 32'h0000_0000;
      end
   end

   // ==========================================
   // Checks
   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (RESET);

   a_mask_reset_zero: assert property ( // RULE2 RULE7 RULE12
      $past(RESET) |-> (in_mask == 10'h000 && out_mask == 10'h000
                        && in_all_mask == 8'h00 && out_all_mask == 8'h00)
   ) else $error("masks not zero after reset");

   a_in_mask_write: assert property ( // RULE3
      wr_in_mask |=> in_mask == ($past(BUS.wdata[9:0]) & 10'h37b)
   ) else $error("IN mask write wrong");

   a_out_mask_write: assert property ( // RULE5
      wr_out_mask |=> out_mask == ($past(BUS.wdata[9:0]) & 10'h35b)
   ) else $error("OUT mask write wrong");

   a_in_gate_ep0: assert property ( // RULE1
      1'b1 |=> in_sum[0] == $past(|(IN_EPS.status[0] & in_mask
                                    & ~{6'h00, IN_EPS.kind[0], 3'h0}))
   ) else $error("IN summary gating wrong");

   a_iso_timeout_ignored: assert property ( // RULE4
      (IN_EPS.kind[2] && IN_EPS.status[2] == 10'h008) |=> !in_sum[2]
   ) else $error("iso timeout raised summary");

   a_setup_ctrl_only: assert property ( // RULE6
      (!OUT_EPS.kind[3] && OUT_EPS.status[3] == 10'h008) |=> !out_sum[3]
   ) else $error("setup done on non-control endpoint");

   a_setup_on_ctrl: assert property ( // RULE6
      (OUT_EPS.kind[1] && OUT_EPS.status[1] == 10'h008 && out_mask[3])
      |=> out_sum[1]
   ) else $error("setup done lost on control endpoint");

   a_sum_follows_clear: assert property ( // RULE11
      (out_sum[5] && OUT_EPS.status[5] == 10'h000) |=> !out_sum[5]
   ) else $error("summary did not clear");

   a_sum_ignores_all: assert property ( // RULE13
      (!in_all_mask[4]
       && (IN_EPS.status[4] & in_mask & ~{6'h00, IN_EPS.kind[4], 3'h0}) != 10'h000)
      |=> in_sum[4]
   ) else $error("summary blocked by all mask");

   a_ep_irq_level: assert property ( // RULE14
      1'b1 |=> EP_IRQ == $past(|({out_sum & out_all_mask,
                                  in_sum & in_all_mask}))
   ) else $error("endpoint request wrong");

   a_summary_read: assert property ( // RULE9
      (BUS.rd && BUS.addr == 8'h08)
      |=> RDATA == {8'h00, $past(out_sum), 8'h00, $past(in_sum)}
   ) else $error("summary read layout wrong");

   a_read_one_cycle: assert property (
      !BUS.rd |=> RDATA == 32'h0000_0000
   ) else $error("read data outside its cycle");

   a_event_set_wins: assert property (
      (ev_set[0] && wr_ev_status && BUS.wdata[0]) |=> ev_status[0]
   ) else $error("event lost on clear");

   // ==========================================
   // Checks: register port layout
   a_in_reserved_zero: assert property ( // RULE3
      (BUS.rd && BUS.addr == 8'h00)
      |=> (RDATA[31:10] == 22'h000000 && RDATA[7] == 1'b0 && RDATA[2] == 1'b0)
   ) else $error("IN mask reserved bit set");

   a_out_reserved_zero: assert property ( // RULE5
      (BUS.rd && BUS.addr == 8'h04)
      |=> (RDATA[31:10] == 22'h000000 && RDATA[7] == 1'b0 && RDATA[5] == 1'b0
           && RDATA[2] == 1'b0)
   ) else $error("OUT mask reserved bit set");

   a_all_mask_write: assert property ( // RULE12
      wr_all_mask |=> (in_all_mask == $past(BUS.wdata[7:0])
                       && out_all_mask == $past(BUS.wdata[23:16]))
   ) else $error("all mask write wrong");

   a_all_mask_read: assert property ( // RULE12
      (BUS.rd && BUS.addr == 8'h0c)
      |=> RDATA == {8'h00, $past(out_all_mask), 8'h00, $past(in_all_mask)}
   ) else $error("all mask read layout wrong");

   a_unmapped_read_zero: assert property (
      (BUS.rd && BUS.addr[7:5] != 3'h0) |=> RDATA == 32'h0000_0000
   ) else $error("unmapped read not zero");

   a_event_read: assert property (
      (BUS.rd && BUS.addr == 8'h10) |=> RDATA == {30'h0, $past(ev_status)}
   ) else $error("event status read wrong");

   a_event_mask_write: assert property (
      wr_ev_mask |=> ev_mask == $past(BUS.wdata[1:0])
   ) else $error("event mask write wrong");

   // ==========================================
   // Checks: gating and summary
   a_in_closed_quiet: assert property ( // RULE1
      in_mask == 10'h000 |=> in_sum == 8'h00
   ) else $error("IN summary set with mask closed");

   a_out_closed_quiet: assert property ( // RULE7
      out_mask == 10'h000 |=> out_sum == 8'h00
   ) else $error("OUT summary set with mask closed");

   a_timeout_non_iso: assert property ( // RULE4
      (!IN_EPS.kind[2] && IN_EPS.status[2][3] && in_mask[3]) |=> in_sum[2]
   ) else $error("timeout lost on non-iso endpoint");

   a_bidir_both: assert property ( // RULE10
      (IN_EPS.status[3][0] && OUT_EPS.status[3][0] && in_mask[0] && out_mask[0])
      |=> (in_sum[3] && out_sum[3])
   ) else $error("bidirectional endpoint lost a summary bit");

   a_out_sum_clears: assert property ( // RULE11
      (out_sum[0] && OUT_EPS.status[0] == 10'h000) |=> !out_sum[0]
   ) else $error("OUT summary did not clear");

   // Summary stays readable, only the request is held back
   a_masked_no_request: assert property ( // RULE13
      (in_sum != 8'h00 && (in_sum & in_all_mask) == 8'h00
       && (out_sum & out_all_mask) == 8'h00) |=> !EP_IRQ
   ) else $error("request raised by masked summary");

   // ==========================================
   // Checks: event interrupt
   // The OUT sticky bit must survive every cycle without a matching clear
   a_event_sticky: assert property (
      (ev_status[1] && !(wr_ev_status && BUS.wdata[1])) |=> ev_status[1]
   ) else $error("OUT event bit dropped");

   a_event_clear: assert property (
      (wr_ev_status && BUS.wdata[1:0] == 2'h3 && ev_set == 2'h0) |=> ev_status == 2'h0
   ) else $error("event bits not cleared");

   a_in_rise_event: assert property (
      $rose(in_sum[4]) |=> ev_status[0]
   ) else $error("IN summary rise not recorded");

   a_out_rise_event: assert property (
      $rose(out_sum[0]) |=> ev_status[1]
   ) else $error("OUT summary rise not recorded");

   a_irq_held: assert property (
      ((ev_status & ev_mask) != 2'h0 && !wr_ev_status && !wr_ev_mask) |=> IRQ
   ) else $error("event interrupt dropped");

   a_irq_quiet: assert property (
      ((ev_status & ev_mask) == 2'h0 && ev_set == 2'h0) |=> !IRQ
   ) else $error("event interrupt without cause");

endmodule
`default_nettype wire

// >>> sim/usb_ep_status_model.sv
// Behavioural model of the per-endpoint interrupt status logic of the device core
`timescale 1ns/1ps
`default_nettype none
module usb_ep_status_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Command: set or clear one status bit
   input wire logic set_ev,
   input wire logic clr_ev,
   input wire logic dir_out,
   input wire logic [2:0] ep,
   input wire logic [3:0] bit_idx,
   // Endpoint kinds
   input wire logic [7:0] in_kind,
   input wire logic [7:0] out_kind,
   // Status toward the block
   output wire usb_ep_irq_pkg::ep_side_type in_eps,
   output wire usb_ep_irq_pkg::ep_side_type out_eps
);
   logic [7:0][9:0] in_st;
   logic [7:0][9:0] out_st;
   // ==========================================
   // Sticky status, dropped only by software clear
   always_ff @(posedge clk) begin
      if (rst) begin
         in_st <= '0;
         out_st <= '0;
      end else if (set_ev || clr_ev) begin
         if (dir_out) begin
            out_st[ep][bit_idx] <= set_ev;
         end else begin
            in_st[ep][bit_idx] <= set_ev;
         end
      end
   end
   assign in_eps = '{in_st, in_kind};
   assign out_eps = '{out_st, out_kind};
endmodule
`default_nettype wire

// >>> sim/usb_ep_irq_mask_tb_top.sv
// Self-checking testbench of the endpoint interrupt mask block
`timescale 1ns/1ps
`default_nettype none
`include "usb_ep_irq_regs.svh"
module usb_ep_irq_mask_tb_top;
   logic sys_clk;
   logic reset;
   usb_ep_irq_pkg::bus_req_type bus;
   logic [31:0] rdata;
   wire usb_ep_irq_pkg::ep_side_type in_eps;
   wire usb_ep_irq_pkg::ep_side_type out_eps;
   logic ep_irq, irq, set_ev, clr_ev, dir_out;
   logic [2:0] ep;
   logic [3:0] bit_idx;
   logic [7:0] in_kind, out_kind;
   int miscompares, n_tests;
   int bits_in[8] = '{0, 1, 3, 4, 5, 6, 8, 9};
   int bits_out[7] = '{0, 1, 3, 4, 6, 8, 9};
   usb_ep_irq_mask usb_ep_irq_mask_inst (.SYS_CLK(sys_clk), .RESET(reset), .BUS(bus), .RDATA(rdata),
      .IN_EPS(in_eps), .OUT_EPS(out_eps), .EP_IRQ(ep_irq), .IRQ(irq));
   usb_ep_status_model usb_ep_status_model_inst (.clk(sys_clk), .rst(reset), .set_ev(set_ev),
      .clr_ev(clr_ev), .dir_out(dir_out), .ep(ep), .bit_idx(bit_idx), .in_kind(in_kind),
      .out_kind(out_kind), .in_eps(in_eps), .out_eps(out_eps));
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // ==========================================
   // Access tasks
   task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // Idle edge after each strobe so no signal is assigned twice in a step
   task wr(input logic [7:0] a, input logic [31:0] d);
      bus <= '{a, d, 1'b1, 1'b0};
      @(posedge sys_clk);
      bus.wr <= 1'b0;
      @(posedge sys_clk);
   endtask
   task rd(input logic [7:0] a, input logic [31:0] exp, input string name);
      bus <= '{a, 32'h0, 1'b0, 1'b1};
      @(posedge sys_clk);
      bus.rd <= 1'b0;
      #1 check(name, rdata, exp);
      @(posedge sys_clk);
   endtask
   task ev(input logic s, input logic d, input int e, input int b);
      set_ev <= s;
      clr_ev <= !s;
      dir_out <= d;
      ep <= e[2:0];
      bit_idx <= b[3:0];
      @(posedge sys_clk);
      set_ev <= 1'b0;
      clr_ev <= 1'b0;
      repeat (3) @(posedge sys_clk);
   endtask
   task chk_irq(input logic e, input logic i, input string name);
      repeat (2) @(posedge sys_clk);
      #1 check(name, {30'h0, ep_irq, irq}, {30'h0, e, i});
      @(posedge sys_clk);
   endtask
   task wrap_up;
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // ==========================================
   // Tests
   initial begin
      reset = 1'b1;
      bus = '0;
      {set_ev, clr_ev, dir_out, ep, bit_idx} = '0;
      in_kind = 8'h00;
      out_kind = 8'hff;
      miscompares = 0;
      n_tests = 0;
      repeat (10) @(posedge sys_clk);
      reset <= 1'b0;
      @(posedge sys_clk);
      rd(`EPI_IN_MASK_OFS, 32'h0, "in_mask_reset");
      rd(`EPI_OUT_MASK_OFS, 32'h0, "out_mask_reset");
      rd(`EPI_ALL_MASK_OFS, 32'h0, "all_mask_reset");
      rd(`EPI_SUMMARY_OFS, 32'h0, "summary_reset");
      $display("test reset_values done");
      wr(`EPI_IN_MASK_OFS, 32'hffffffff);
      rd(`EPI_IN_MASK_OFS, 32'h37b, "in_mask_bits");
      wr(`EPI_OUT_MASK_OFS, 32'hffffffff);
      rd(`EPI_OUT_MASK_OFS, 32'h35b, "out_mask_bits");
      wr(`EPI_SUMMARY_OFS, 32'hffffffff);
      rd(`EPI_SUMMARY_OFS, 32'h0, "summary_read_only");
      rd(8'h40, 32'h0, "unmapped");
      wr(`EPI_ALL_MASK_OFS, 32'hffffffff);
      rd(`EPI_ALL_MASK_OFS, 32'h00ff00ff, "all_mask_bits");
      wr(`EPI_ALL_MASK_OFS, 32'h0);
      ev(1'b1, 1'b0, 1, 2);
      rd(`EPI_SUMMARY_OFS, 32'h0, "in_reserved_gate");
      ev(1'b0, 1'b0, 1, 2);
      $display("test register_access done");
      // One mask bit per pass, each on its own endpoint
      for (int i = 0; i < 8; i++) begin
         wr(`EPI_IN_MASK_OFS, 32'h1 << bits_in[i]);
         ev(1'b1, 1'b0, i, bits_in[i]);
         rd(`EPI_SUMMARY_OFS, 32'h1 << i, "in_gate_open");
         wr(`EPI_IN_MASK_OFS, 32'h0);
         rd(`EPI_SUMMARY_OFS, 32'h0, "in_gate_shut");
         ev(1'b0, 1'b0, i, bits_in[i]);
         if (i < 7) begin
            wr(`EPI_OUT_MASK_OFS, 32'h1 << bits_out[i]);
            ev(1'b1, 1'b1, i, bits_out[i]);
            rd(`EPI_SUMMARY_OFS, 32'h1 << (16 + i), "out_gate_open");
            ev(1'b0, 1'b1, i, bits_out[i]);
            rd(`EPI_SUMMARY_OFS, 32'h0, "out_sw_clear");
         end
      end
      $display("test gating done");
      wr(`EPI_IN_MASK_OFS, 32'h8);
      in_kind <= 8'h04;
      ev(1'b1, 1'b0, 2, 3);
      rd(`EPI_SUMMARY_OFS, 32'h0, "iso_timeout");
      in_kind <= 8'h00;
      repeat (3) @(posedge sys_clk);
      rd(`EPI_SUMMARY_OFS, 32'h4, "bulk_timeout");
      ev(1'b0, 1'b0, 2, 3);
      wr(`EPI_OUT_MASK_OFS, 32'h8);
      out_kind <= 8'hdf;
      ev(1'b1, 1'b1, 5, 3);
      rd(`EPI_SUMMARY_OFS, 32'h0, "setup_non_control");
      out_kind <= 8'hff;
      repeat (3) @(posedge sys_clk);
      rd(`EPI_SUMMARY_OFS, 32'h00200000, "setup_control");
      ev(1'b0, 1'b1, 5, 3);
      $display("test qualifiers done");
      wr(`EPI_IN_MASK_OFS, 32'h1);
      wr(`EPI_OUT_MASK_OFS, 32'h1);
      ev(1'b1, 1'b0, 3, 0);
      ev(1'b1, 1'b1, 3, 0);
      rd(`EPI_SUMMARY_OFS, 32'h00080008, "bidir_summary");
      chk_irq(1'b0, 1'b0, "ep_irq_masked");
      wr(`EPI_ALL_MASK_OFS, 32'h00080000);
      chk_irq(1'b1, 1'b0, "ep_irq_out");
      ev(1'b0, 1'b1, 3, 0);
      chk_irq(1'b0, 1'b0, "ep_irq_cleared");
      rd(`EPI_SUMMARY_OFS, 32'h8, "summary_after_clear");
      wr(`EPI_ALL_MASK_OFS, 32'h8);
      chk_irq(1'b1, 1'b0, "ep_irq_in");
      wr(`EPI_ALL_MASK_OFS, 32'h0);
      $display("test summary_mask done");
      wr(`EPI_EV_MASK_OFS, 32'h3);
      chk_irq(1'b0, 1'b1, "event_irq_on");
      rd(`EPI_EV_STATUS_OFS, 32'h3, "event_both_set");
      wr(`EPI_EV_STATUS_OFS, 32'h3);
      rd(`EPI_EV_STATUS_OFS, 32'h0, "event_cleared");
      chk_irq(1'b0, 1'b0, "event_irq_off");
      ev(1'b1, 1'b0, 4, 0);
      rd(`EPI_EV_STATUS_OFS, 32'h1, "event_in_rise");
      chk_irq(1'b0, 1'b1, "event_irq_again");
      // Rise of IN endpoint 5 meets a clear of bit 0 on one edge
      set_ev <= 1'b1;
      {dir_out, ep, bit_idx} <= {1'b0, 3'd5, 4'd0};
      @(posedge sys_clk);
      set_ev <= 1'b0;
      @(posedge sys_clk);
      wr(`EPI_EV_STATUS_OFS, 32'h1);
      rd(`EPI_EV_STATUS_OFS, 32'h1, "event_set_wins");
      $display("test event_irq done");
      // Second reset in mid-run must drop the written masks
      reset <= 1'b1;
      repeat (2) @(posedge sys_clk);
      reset <= 1'b0;
      @(posedge sys_clk);
      rd(`EPI_IN_MASK_OFS, 32'h0, "in_mask_rerun");
      rd(`EPI_OUT_MASK_OFS, 32'h0, "out_mask_rerun");
      rd(`EPI_SUMMARY_OFS, 32'h0, "summary_rerun");
      chk_irq(1'b0, 1'b0, "irq_rerun");
      $display("test mid_run_reset done");
      wrap_up();
   end
   // Whole run needs well under 5000 cycles
   initial begin
      #100us;
      miscompares++;
      wrap_up();
   end
endmodule
`default_nettype wire
